// ===== hdl/ptmr_master.sv
module ptmr_master #(
  parameter int CONV_TEMP_CYC = ptmr_pkg::CONV_TEMP_CYC,
  parameter int CONV_P0_CYC = ptmr_pkg::CONV_P0_CYC,
  parameter int CONV_P1_CYC = ptmr_pkg::CONV_P1_CYC,
  parameter int CONV_P2_CYC = ptmr_pkg::CONV_P2_CYC,
  parameter int CONV_P3_CYC = ptmr_pkg::CONV_P3_CYC,
  parameter int QUARTER_CYC = ptmr_pkg::QUARTER_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  ptmr_if.master bus
);
  import ptmr_pkg::*;

  localparam int TMR_W = $clog2(CONV_P3_CYC + 1);
  localparam int DIV_W = $clog2(QUARTER_CYC + 1);

  logic [1:0] sda_sync_reg;
  logic sda_in;
  logic [DIV_W-1:0] div_reg;
  logic tick;
  logic [31:0] prdata_reg, prdata_next;
  logic pready_reg, pready_next;
  logic pslverr_reg, pslverr_next;
  logic cmd_we;
  logic busy;
  ptmr_mst_t st_reg, st_next;
  ptmr_step_t step_reg, step_next, ns;
  logic [1:0] q_reg, q_next;
  logic [3:0] bit_reg, bit_next;
  logic [1:0] left_reg, left_next;
  logic [7:0] sh_reg, sh_next;
  logic [23:0] rdata_reg, rdata_next;
  logic nack_reg, nack_next;
  logic scl_oe_reg, scl_oe_next;
  logic sda_oe_reg, sda_oe_next;
  logic [CMD_W-1:0] creg_reg, creg_next;
  logic done;
  logic nack_now;
  logic stop_el;
  logic rd;
  logic guard_load;
  logic [TMR_W-1:0] guard_reg, guard_next;

  function automatic ptmr_step_t next_step(input ptmr_step_t s, input logic r);
    unique case (s)
      ST_START: return ST_ADDR_W;
      ST_ADDR_W: return ST_REG;
      ST_REG: return ST_MID;
      ST_MID: return r ? ST_ADDR_R : ST_STOP;
      ST_ADDR_R: return ST_READ;
      default: return ST_STOP;
    endcase
  endfunction

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync_reg <= 2'h3;
      div_reg <= '0;
    end else begin
      sda_sync_reg <= {sda_sync_reg[0], bus.sda};
      div_reg <= tick ? DIV_W'(QUARTER_CYC - 1) : div_reg - DIV_W'(1);
    end
  end

  assign sda_in = sda_sync_reg[1];
  assign tick = (div_reg == '0);
  assign busy = (st_reg != M_IDLE);
  assign rd = creg_reg[CMD_RD_BIT];
  assign stop_el = (step_reg == ST_STOP);
  assign cmd_we = psel & penable & pready_reg & pwrite & (paddr == HR_CMD) & ~busy;

  // APB slave: zero wait states, response prepared in the setup cycle
  always_comb begin
    pready_next = psel & ~penable;
    prdata_next = prdata_reg;
    pslverr_next = 1'b0;
    if (psel && !penable) begin
      prdata_next = 32'h0000_0000;
      if (paddr == HR_CMD) begin
        prdata_next[CMD_W-1:0] = creg_reg;
        pslverr_next = pwrite & busy;
      end else if (paddr == HR_STATUS) begin
        prdata_next[STAT_BUSY_BIT] = busy;
        prdata_next[STAT_NACK_BIT] = nack_reg;
      end else if (paddr == HR_RDATA) begin
        prdata_next[23:0] = rdata_reg;
      end else begin
        pslverr_next = 1'b1;
      end
    end
  end

  always_comb begin
    st_next = st_reg;
    step_next = step_reg;
    q_next = q_reg;
    bit_next = bit_reg;
    left_next = left_reg;
    sh_next = sh_reg;
    rdata_next = rdata_reg;
    nack_next = nack_reg;
    scl_oe_next = scl_oe_reg;
    sda_oe_next = sda_oe_reg;
    creg_next = creg_reg;
    done = 1'b0;
    nack_now = 1'b0;
    guard_load = 1'b0;
    ns = next_step(step_reg, rd);
    unique case (st_reg)
      M_IDLE: begin
        if (cmd_we) begin
          creg_next = pwdata[CMD_W-1:0];
          left_next = pwdata[CMD_CNT_LSB+:2];
          nack_next = 1'b0;
          rdata_next = 24'h000000;
          st_next = M_HOLD;
        end
      end
      M_HOLD: begin
        if (tick && (!rd || guard_reg == '0)) begin // [R3]
          st_next = M_COND;
          step_next = ST_START;
          q_next = 2'h0;
        end
      end
      M_COND: begin
        if (tick) begin
          q_next = q_reg + 2'h1;
          unique case (q_reg)
            2'h0: begin
              scl_oe_next = 1'b1;
              sda_oe_next = stop_el;
            end
            2'h1: scl_oe_next = 1'b0;
            2'h2: sda_oe_next = ~stop_el; // [R4] [R7] [R9] [R14]
            2'h3: begin
              scl_oe_next = ~stop_el;
              done = 1'b1;
            end
          endcase
        end
      end
      M_TX: begin
        if (tick) begin
          q_next = q_reg + 2'h1;
          unique case (q_reg)
            2'h0: sda_oe_next = (bit_reg == 4'h8) ? 1'b0 : ~sh_reg[7];
            2'h1: scl_oe_next = 1'b0;
            2'h2: scl_oe_next = 1'b0;
            2'h3: begin
              scl_oe_next = 1'b1;
              if (bit_reg == 4'h8) begin
                done = 1'b1;
                nack_now = sda_in;
              end else begin
                sh_next = {sh_reg[6:0], 1'b0};
                bit_next = bit_reg + 4'h1;
              end
            end
          endcase
        end
      end
      M_RX: begin
        if (tick) begin
          q_next = q_reg + 2'h1;
          unique case (q_reg)
            2'h0: sda_oe_next = (bit_reg == 4'h8) && (left_reg != 2'h0); // [R8] [R9]
            2'h1: scl_oe_next = 1'b0;
            2'h2: scl_oe_next = 1'b0;
            2'h3: begin
              scl_oe_next = 1'b1;
              if (bit_reg == 4'h8) begin
                done = 1'b1;
              end else begin
                rdata_next = {rdata_reg[22:0], sda_in}; // [R8]
                bit_next = bit_reg + 4'h1;
              end
            end
          endcase
        end
      end
      default: st_next = M_IDLE;
    endcase
    if (done) begin
      if (stop_el) begin
        st_next = M_IDLE;
        guard_load = ~rd & ~nack_reg & (creg_reg[CMD_ADDR_LSB+:8] == REG_CMD); // [R3]
      end else begin
        if (nack_now) begin
          nack_next = 1'b1;
          ns = ST_STOP;
        end else if (st_reg == M_RX && left_reg != 2'h0) begin
          left_next = left_reg - 2'h1;
          ns = ST_READ;
        end
        step_next = ns;
        bit_next = 4'h0;
        st_next = M_TX;
        if (ns == ST_STOP || ns == ST_START || (ns == ST_MID && rd)) begin
          st_next = M_COND;
        end else if (ns == ST_READ) begin
          st_next = M_RX;
        end
        unique case (ns)
          ST_ADDR_W: sh_next = ADDR_WR; // [R4] [R13]
          ST_REG: sh_next = creg_reg[CMD_ADDR_LSB+:8]; // [R1] [R4]
          ST_MID: sh_next = creg_reg[CMD_DATA_LSB+:8]; // [R1] [R2] [R14]
          ST_ADDR_R: sh_next = ADDR_RD; // [R7] [R13]
          default: sh_next = sh_reg;
        endcase
      end
    end
  end

  // Read hold-off after a conversion command
  always_comb begin
    guard_next = guard_reg;
    if (guard_load) begin
      unique case (ptmr_decode_cmd(creg_reg[CMD_DATA_LSB+:8]))
        CONV_TEMP: guard_next = TMR_W'(CONV_TEMP_CYC); // [R3]
        CONV_P0: guard_next = TMR_W'(CONV_P0_CYC);
        CONV_P1: guard_next = TMR_W'(CONV_P1_CYC);
        CONV_P2: guard_next = TMR_W'(CONV_P2_CYC);
        CONV_P3: guard_next = TMR_W'(CONV_P3_CYC);
        default: guard_next = guard_reg;
      endcase
    end else if (guard_reg != '0) begin
      guard_next = guard_reg - TMR_W'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      st_reg <= M_IDLE;
      step_reg <= ST_START;
      q_reg <= 2'h0;
      bit_reg <= 4'h0;
      left_reg <= 2'h0;
      sh_reg <= 8'h00;
      rdata_reg <= 24'h000000;
      nack_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      creg_reg <= '0;
      guard_reg <= '0;
    end else begin
      prdata_reg <= prdata_next;
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      st_reg <= st_next;
      step_reg <= step_next;
      q_reg <= q_next;
      bit_reg <= bit_next;
      left_reg <= left_next;
      sh_reg <= sh_next;
      rdata_reg <= rdata_next;
      nack_reg <= nack_next;
      scl_oe_reg <= scl_oe_next;
      sda_oe_reg <= sda_oe_next;
      creg_reg <= creg_next;
      guard_reg <= guard_next;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign bus.m_scl_oe = scl_oe_reg;
  assign bus.m_sda_oe = sda_oe_reg;
endmodule

// ===== hdl/ptmr_pkg.sv
package ptmr_pkg;
  localparam real CLK_MHZ = 100.0;
  localparam real CLK_PERIOD_NS = 10.0;
  localparam real SCL_PERIOD_NS = 160.0;
  localparam int QUARTER_CYC = int'($floor(SCL_PERIOD_NS / 4.0 / CLK_PERIOD_NS));

  localparam logic [7:0] ADDR_WR = 8'hEE;
  localparam logic [7:0] ADDR_RD = 8'hEF;

  localparam logic [7:0] REG_CALIB_FIRST = 8'hAA;
  localparam logic [7:0] REG_CALIB_LAST = 8'hBF;
  localparam logic [7:0] REG_CMD = 8'hF4;
  localparam logic [7:0] REG_RES_HI = 8'hF6;
  localparam logic [7:0] REG_RES_LO = 8'hF7;
  localparam logic [7:0] REG_RES_XL = 8'hF8;

  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [7:0] RES_HI_RST = 8'h80;
  localparam logic [7:0] RES_LO_RST = 8'h00;
  localparam logic [7:0] RES_XL_RST = 8'h00;

  // Command codes: temperature, and pressure with oversampling in bits 7:6
  localparam logic [7:0] CMD_TEMP = 8'h2E;
  localparam logic [5:0] CMD_PRESS_LOW = 6'h34;
  localparam int SCO_BIT = 5;
  localparam int OSS_LSB = 6;

  localparam real T_TEMP_MS = 4.5;
  localparam real T_P0_MS = 4.5;
  localparam real T_P1_MS = 7.5;
  localparam real T_P2_MS = 13.5;
  localparam real T_P3_MS = 25.5;
  localparam int CONV_TEMP_CYC = int'($floor(T_TEMP_MS * CLK_MHZ * 1000.0));
  localparam int CONV_P0_CYC = int'($floor(T_P0_MS * CLK_MHZ * 1000.0));
  localparam int CONV_P1_CYC = int'($floor(T_P1_MS * CLK_MHZ * 1000.0));
  localparam int CONV_P2_CYC = int'($floor(T_P2_MS * CLK_MHZ * 1000.0));
  localparam int CONV_P3_CYC = int'($floor(T_P3_MS * CLK_MHZ * 1000.0));

  // Controller registers on APB
  localparam logic [7:0] HR_CMD = 8'h00;
  localparam logic [7:0] HR_STATUS = 8'h04;
  localparam logic [7:0] HR_RDATA = 8'h08;
  localparam int CMD_ADDR_LSB = 0;
  localparam int CMD_DATA_LSB = 8;
  localparam int CMD_RD_BIT = 16;
  localparam int CMD_CNT_LSB = 17;
  localparam int CMD_W = 19;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_NACK_BIT = 1;

  typedef enum logic [2:0] {
    CONV_NONE = 3'h0,
    CONV_TEMP = 3'h1,
    CONV_P0 = 3'h4,
    CONV_P1 = 3'h5,
    CONV_P2 = 3'h6,
    CONV_P3 = 3'h7
  } ptmr_conv_t;

  typedef enum logic [2:0] {
    S_IDLE = 3'h0, S_ADDR = 3'h1, S_ACK = 3'h3, S_RX = 3'h2, S_TX = 3'h6, S_MACK = 3'h7
  } ptmr_sst_t;

  typedef enum logic [2:0] {
    M_IDLE = 3'h0, M_HOLD = 3'h1, M_COND = 3'h3, M_TX = 3'h2, M_RX = 3'h6
  } ptmr_mst_t;

  typedef enum logic [2:0] {
    ST_START = 3'h0, ST_ADDR_W = 3'h1, ST_REG = 3'h3, ST_MID = 3'h2,
    ST_ADDR_R = 3'h6, ST_READ = 3'h7, ST_STOP = 3'h5
  } ptmr_step_t;

  function automatic ptmr_conv_t ptmr_decode_cmd(input logic [7:0] code);
    ptmr_conv_t k;
    k = CONV_NONE;
    if (code == CMD_TEMP) begin
      k = CONV_TEMP;
    end else if (code[5:0] == CMD_PRESS_LOW) begin
      k = ptmr_conv_t'({1'b1, code[OSS_LSB+:2]});
    end
    return k;
  endfunction
endpackage

// ===== hdl/ptmr_if.sv
interface ptmr_if;
  logic m_scl_oe;
  logic m_sda_oe;
  logic s_sda_oe;
  logic scl;
  logic sda;
  // Open-drain lines: any enabled driver pulls low
  assign scl = ~m_scl_oe;
  assign sda = ~(m_sda_oe | s_sda_oe);
  modport master (output m_scl_oe, output m_sda_oe, input scl, input sda);
  modport sensor (output s_sda_oe, input scl, input sda);
endinterface

// ===== hdl/ptmr_sensor.sv
// Contract
// [R1] Command 0x2E at 0xF4 starts temperature
// [R2] Pressure codes select oversampling zero to three
// [R3] Conversion ends within its maximum time
// [R4] Master sends start, write address, register byte
// [R5] Calibration bytes read at 0xAA..0xBF
// [R6] Result bytes at 0xF6, 0xF7, 0xF8
// [R7] Repeated start, read address, sensor acknowledges
// [R8] Most significant byte sent first, master acknowledges
// [R9] Master ends read with not-acknowledge, stop
// [R10] Extra low bits extend pressure to 19
// [R11] Temperature word spans high and low bytes
// [R12] Conversion-active bit high until results filled
// [R13] Address bytes 0xEE write, 0xEF read
// [R14] Write: address, register, data, sensor_acknowledge, stop
// [R15] Results stay stable until next completion
module ptmr_sensor #(
  parameter int CONV_TEMP_CYC = ptmr_pkg::CONV_TEMP_CYC,
  parameter int CONV_P0_CYC = ptmr_pkg::CONV_P0_CYC,
  parameter int CONV_P1_CYC = ptmr_pkg::CONV_P1_CYC,
  parameter int CONV_P2_CYC = ptmr_pkg::CONV_P2_CYC,
  parameter int CONV_P3_CYC = ptmr_pkg::CONV_P3_CYC,
  // Arbitrary calibration pattern
  parameter logic [7:0] CALIB_SEED = 8'h5A,
  parameter logic [7:0] CALIB_STEP = 8'h3B
) (
  input wire logic pclk,
  input wire logic presetn,
  ptmr_if.sensor bus,
  input wire logic [15:0] temp_sample,
  input wire logic [18:0] press_sample,
  output ptmr_pkg::ptmr_conv_t conv_kind,
  output logic conv_busy
);
  import ptmr_pkg::*;

  localparam int TMR_W = $clog2(CONV_P3_CYC + 1);

  logic [2:0] scl_sync_reg;
  logic [2:0] sda_sync_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic sda_in;

  ptmr_sst_t st_reg, st_next;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [7:0] ptr_reg, ptr_next;
  logic rw_reg, rw_next;
  logic first_reg, first_next;
  logic mack_reg, mack_next;
  logic oe_reg, oe_next;
  logic load;
  logic cmd_we;
  logic [7:0] rd_byte;

  logic [7:0] cmd_reg, cmd_next;
  logic [7:0] hi_reg, hi_next;
  logic [7:0] lo_reg, lo_next;
  logic [7:0] xl_reg, xl_next;
  logic busy_reg, busy_next;
  ptmr_conv_t kind_reg, kind_next;
  ptmr_conv_t new_kind;
  logic [TMR_W-1:0] tmr_reg, tmr_next;
  logic [TMR_W-1:0] tmr_load;
  logic [2:0] xmask;

  // Second and third stages feed the edge and condition detectors
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], bus.scl};
      sda_sync_reg <= {sda_sync_reg[1:0], bus.sda};
    end
  end

  assign sda_in = sda_sync_reg[1];
  assign scl_rise = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_det = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[1] & sda_sync_reg[2];
  assign stop_det = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[1] & ~sda_sync_reg[2];

  // Register read mux
  always_comb begin
    rd_byte = 8'h00;
    if (ptr_reg >= REG_CALIB_FIRST && ptr_reg <= REG_CALIB_LAST) begin
      rd_byte = ((ptr_reg - REG_CALIB_FIRST) * CALIB_STEP) ^ CALIB_SEED; // [R5]
    end else if (ptr_reg == REG_CMD) begin
      rd_byte = cmd_reg;
      rd_byte[SCO_BIT] = busy_reg; // [R12]
    end else if (ptr_reg == REG_RES_HI) begin
      rd_byte = hi_reg; // [R6]
    end else if (ptr_reg == REG_RES_LO) begin
      rd_byte = lo_reg; // [R6]
    end else if (ptr_reg == REG_RES_XL) begin
      rd_byte = xl_reg; // [R6]
    end
  end

  always_comb begin
    st_next = st_reg;
    sh_next = sh_reg;
    cnt_next = cnt_reg;
    ptr_next = ptr_reg;
    rw_next = rw_reg;
    first_next = first_reg;
    mack_next = mack_reg;
    oe_next = oe_reg;
    load = 1'b0;
    cmd_we = 1'b0;
    if (start_det) begin
      st_next = S_ADDR; // [R4] [R7]
      cnt_next = 4'h0;
      oe_next = 1'b0;
    end else if (stop_det) begin
      st_next = S_IDLE;
      oe_next = 1'b0;
    end else begin
      unique case (st_reg)
        S_IDLE: begin
          oe_next = 1'b0;
        end
        S_ADDR, S_RX: begin
          if (scl_rise) begin
            sh_next = {sh_reg[6:0], sda_in};
            cnt_next = cnt_reg + 4'h1;
          end else if (scl_fall && cnt_reg == 4'h8) begin
            if (st_reg == S_ADDR) begin
              if (sh_reg[7:1] == ADDR_WR[7:1]) begin // [R13]
                rw_next = sh_reg[0];
                first_next = ~sh_reg[0];
                oe_next = 1'b1; // [R7]
                st_next = S_ACK;
              end else begin
                st_next = S_IDLE;
              end
            end else begin
              if (first_reg) begin
                ptr_next = sh_reg; // [R4]
              end else begin
                cmd_we = (ptr_reg == REG_CMD); // [R14]
                ptr_next = ptr_reg + 8'h01;
              end
              first_next = 1'b0;
              oe_next = 1'b1; // [R14]
              st_next = S_ACK;
            end
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            if (rw_reg) begin
              load = 1'b1;
            end else begin
              oe_next = 1'b0;
              cnt_next = 4'h0;
              st_next = S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_reg == 4'h7) begin
              oe_next = 1'b0;
              st_next = S_MACK;
            end else begin
              sh_next = {sh_reg[6:0], 1'b0}; // [R8]
              oe_next = ~sh_reg[6];
              cnt_next = cnt_reg + 4'h1;
            end
          end
        end
        S_MACK: begin
          if (scl_rise) begin
            mack_next = ~sda_in; // [R8]
          end else if (scl_fall) begin
            if (mack_reg) begin
              load = 1'b1;
            end else begin
              st_next = S_IDLE; // [R9]
            end
          end
        end
        default: begin
          st_next = S_IDLE;
          oe_next = 1'b0;
        end
      endcase
    end
    if (load) begin
      sh_next = rd_byte; // [R8]
      oe_next = ~rd_byte[7];
      cnt_next = 4'h0;
      ptr_next = ptr_reg + 8'h01;
      st_next = S_TX;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      sh_reg <= 8'h00;
      cnt_reg <= 4'h0;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      first_reg <= 1'b0;
      mack_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      sh_reg <= sh_next;
      cnt_reg <= cnt_next;
      ptr_reg <= ptr_next;
      rw_reg <= rw_next;
      first_reg <= first_next;
      mack_reg <= mack_next;
      oe_reg <= oe_next;
    end
  end

  assign new_kind = ptmr_decode_cmd(sh_reg);
  assign xmask = ~(3'h7 >> kind_reg[1:0]);

  always_comb begin
    unique case (new_kind)
      CONV_TEMP: tmr_load = TMR_W'(CONV_TEMP_CYC - 1);
      CONV_P0: tmr_load = TMR_W'(CONV_P0_CYC - 1);
      CONV_P1: tmr_load = TMR_W'(CONV_P1_CYC - 1);
      CONV_P2: tmr_load = TMR_W'(CONV_P2_CYC - 1);
      CONV_P3: tmr_load = TMR_W'(CONV_P3_CYC - 1);
      default: tmr_load = '0;
    endcase
  end

  // Conversion engine
  always_comb begin
    cmd_next = cmd_reg;
    hi_next = hi_reg;
    lo_next = lo_reg;
    xl_next = xl_reg;
    busy_next = busy_reg;
    kind_next = kind_reg;
    tmr_next = tmr_reg;
    if (cmd_we) begin
      cmd_next = sh_reg;
      if (new_kind != CONV_NONE) begin
        busy_next = 1'b1; // [R1] [R2] [R12]
        kind_next = new_kind;
        tmr_next = tmr_load; // [R3]
      end
    end else if (busy_reg) begin
      if (tmr_reg == '0) begin
        busy_next = 1'b0; // [R12] [R15]
        if (kind_reg == CONV_TEMP) begin
          hi_next = temp_sample[15:8]; // [R11]
          lo_next = temp_sample[7:0];
          xl_next = 8'h00;
        end else begin
          hi_next = press_sample[18:11];
          lo_next = press_sample[10:3];
          xl_next = {press_sample[2:0] & xmask, 5'h00}; // [R2] [R10]
        end
      end else begin
        tmr_next = tmr_reg - TMR_W'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg <= CMD_RST;
      hi_reg <= RES_HI_RST;
      lo_reg <= RES_LO_RST;
      xl_reg <= RES_XL_RST;
      busy_reg <= 1'b0;
      kind_reg <= CONV_NONE;
      tmr_reg <= '0;
    end else begin
      cmd_reg <= cmd_next;
      hi_reg <= hi_next;
      lo_reg <= lo_next;
      xl_reg <= xl_next;
      busy_reg <= busy_next;
      kind_reg <= kind_next;
      tmr_reg <= tmr_next;
    end
  end

  assign bus.s_sda_oe = oe_reg;
  assign conv_busy = busy_reg;
  assign conv_kind = kind_reg;
endmodule

// ===== dv/ptmr_checker.sv
module ptmr_checker #(
  parameter int TEMP_LIM = 450000,
  parameter int P0_LIM = 450000,
  parameter int P1_LIM = 750000,
  parameter int P2_LIM = 1350000,
  parameter int P3_LIM = 2550000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic m_scl_oe,
  input wire logic m_sda_oe,
  input wire logic s_sda_oe,
  input wire logic scl,
  input wire ptmr_pkg::ptmr_conv_t conv_kind,
  input wire logic conv_busy
);
  import ptmr_pkg::*;
  int cnt_reg;
  int cnt_next;
  int lim;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Length of the running conversion and its ceiling
  always_comb begin
    cnt_next = conv_busy ? cnt_reg + 1 : 0;
    case (conv_kind)
      CONV_TEMP: lim = TEMP_LIM;
      CONV_P0: lim = P0_LIM;
      CONV_P1: lim = P1_LIM;
      CONV_P2: lim = P2_LIM;
      CONV_P3: lim = P3_LIM;
      default: lim = 0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_reg <= 0;
    else cnt_reg <= cnt_next;
  end

  chk_conv_time: assert property ($fell(conv_busy) |-> cnt_reg > 0 && cnt_reg <= lim)
    else $error("conversion time out of range");
  chk_kind_set: assert property ($rose(conv_busy) |-> conv_kind != CONV_NONE)
    else $error("conversion started without a kind");
  chk_kind_cause: assert property ($changed(conv_kind) |-> ##[0:2] conv_busy)
    else $error("kind changed without a conversion");
  chk_kind_hold: assert property (conv_busy && $past(conv_busy) |-> $stable(conv_kind))
    else $error("kind changed during conversion");
  chk_sda_lowscl: assert property ($changed(s_sda_oe) |-> !scl)
    else $error("sensor moved data while clock high");
  chk_ack_hold: assert property ($rose(s_sda_oe) |-> s_sda_oe [*8])
    else $error("sensor bit too short");
  chk_scl_high: assert property ($fell(m_scl_oe) |-> !m_scl_oe [*7])
    else $error("clock high phase too short");
  chk_cond_edge: assert property ($changed(m_sda_oe) && scl |-> scl [*3])
    else $error("data edge under high clock not a condition");
endmodule

// ===== dv/pressure_temp_measure_readout_tb.sv
module pressure_temp_measure_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import ptmr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, conv_busy;
  logic [15:0] temp_sample = '0;
  logic [18:0] press_sample = '0;
  ptmr_conv_t conv_kind;
  int n_fail = 0, n_compared = 0, run = 0, blen = 0;
  int lims[4] = '{200, 300, 400, 500};
  logic [7:0] codes[5] = '{8'h2E, 8'h34, 8'h74, 8'hB4, 8'hF4};
  ptmr_if bus_if();
  ptmr_master #(200, 200, 300, 400, 500, 4) ptmr_master_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if.master));
  ptmr_sensor #(200, 200, 300, 400, 500) ptmr_sensor_i (.pclk(pclk), .presetn(presetn),
    .bus(bus_if.sensor), .temp_sample(temp_sample), .press_sample(press_sample),
    .conv_kind(conv_kind), .conv_busy(conv_busy));
  ptmr_checker #(200, 200, 300, 400, 500) ptmr_checker_i (.pclk(pclk), .presetn(presetn),
    .m_scl_oe(bus_if.m_scl_oe), .m_sda_oe(bus_if.m_sda_oe), .s_sda_oe(bus_if.s_sda_oe),
    .scl(bus_if.scl), .conv_kind(conv_kind), .conv_busy(conv_busy));

  initial forever #5 pclk = ~pclk;

  // Length of each conversion, taken when busy drops
  always @(posedge pclk) begin
    if (conv_busy === 1) run <= run + 1;
    else if (run != 0) begin
      blen <= run;
      run <= 0;
    end
  end

  function automatic logic [7:0] cal(logic [7:0] a);
    return ((a - 8'hAA) * 8'h3B) ^ 8'h5A;
  endfunction

  function automatic logic [31:0] res(logic [7:0] c, logic [15:0] t, logic [18:0] p);
    logic [2:0] m;
    m = 3'b111 << (3 - c[7:6]);
    if (c == 8'h2E) return {8'h0, t, 8'h0};
    return {8'h0, p[18:3], p[2:0] & m, 5'h0};
  endfunction

  task automatic conclude();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin
      @(posedge pclk);
    end while (pready !== 1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic xfer(logic r, logic [7:0] a, logic [7:0] d, int n);
    apb(1, HR_CMD, {13'h0, 2'(n - 1), r, d, a});
    chk("cmd error", 0, er);
    // A second command while the first runs must be refused
    apb(1, HR_CMD, 0);
    chk("busy refusal", 1, er);
    do begin
      apb(0, HR_STATUS, 0);
    end while (rd[STAT_BUSY_BIT] !== 0);
    chk("nack", 0, rd[STAT_NACK_BIT]);
    apb(0, HR_RDATA, 0);
  endtask

  initial begin
    logic [15:0] t;
    logic [18:0] p;
    logic [7:0] a;
    int k;
    void'($urandom(2770));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    xfer(0, REG_RES_HI, 8'h12, 1);
    xfer(1, REG_RES_HI, 0, 3);
    chk("result reset", 32'h0080_0000, rd);
    apb(0, 8'h0C, 0);
    chk("unmapped", 1, er);
    for (int i = 0; i < 6; i++) begin
      a = i == 0 ? 8'hAA : i == 1 ? 8'hBE : 8'($urandom_range(8'hAA, 8'hBE));
      xfer(1, a, 0, 2);
      chk("calib", {16'h0, cal(a), cal(a + 8'h1)}, rd);
    end
    foreach (codes[i]) begin
      temp_sample <= 16'($urandom);
      press_sample <= 19'($urandom);
      blen = 0;
      xfer(0, REG_CMD, codes[i], 1);
      t = temp_sample;
      p = press_sample;
      do begin
        @(posedge pclk);
      end while (conv_busy !== 0);
      @(posedge pclk);
      chk("kind", codes[i] == 8'h2E ? CONV_TEMP : {1'b1, codes[i][7:6]}, conv_kind);
      k = codes[i] == 8'h2E ? 200 : lims[codes[i][7:6]];
      chk("conv time", 1, blen > 0 && blen <= k);
      temp_sample <= ~temp_sample;
      press_sample <= ~press_sample;
      xfer(1, REG_CMD, 0, 1);
      chk("ctrl", codes[i] & 8'hDF, rd);
      xfer(1, REG_RES_HI, 0, 3);
      chk("result", res(codes[i], t, p), rd);
    end
    // Read ordered right after a start must wait for the new result
    temp_sample <= 16'($urandom);
    xfer(0, REG_CMD, CMD_TEMP, 1);
    t = temp_sample;
    xfer(1, REG_RES_HI, 0, 2);
    chk("guarded read", {16'h0, t}, rd);
    conclude();
  end

  initial begin
    #800us;
    n_fail++;
    conclude();
  end
endmodule
